/* core/tap_pkg.sv */
// Shared constants and types of the boundary-scan test port
package tap_pkg;
  // ----------------------------------------------------------------
  // Register sizes
  // ----------------------------------------------------------------
  localparam int CHAIN_LEN = 199;
  localparam int ID_LEN = 32;
  localparam int INSTRUCTION_REGISTER_LEN = 3;
  // ----------------------------------------------------------------
  // Instruction codes and capture values
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_EXTEST = 3'h0;
  localparam logic [2:0] OP_SAMPLE = 3'h1;
  localparam logic [2:0] OP_CLAMP = 3'h2;
  localparam logic [2:0] OP_HIGHZ = 3'h3;
  localparam logic [2:0] OP_IDCODE = 3'h5;
  localparam logic [2:0] OP_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic BYPASS_CAPTURE = 1'h0;
  // ----------------------------------------------------------------
  // Pin synchroniser layout: tck, tms, tdi, trst_n, debug select
  // ----------------------------------------------------------------
  localparam int SYNC_W = 5;
  localparam int S_TCK = 0;
  localparam int S_TMS = 1;
  localparam int S_TDI = 2;
  localparam int S_TRSTN = 3;
  localparam int S_DBG = 4;
  // Pulled-up pins idle high, the debug select idles low
  localparam logic [4:0] SYNC_RST = 5'h0f;
  // Buffer entry: bit 1 marks an instruction bit, bit 0 the data
  localparam int BUF_W = 2;
  localparam int BUF_DEPTH = 2;
  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    TLR = 16'h0001, RTI = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
    SH_DR = 16'h0010, EX1_DR = 16'h0020, PA_DR = 16'h0040, EX2_DR = 16'h0080,
    UPD_DR = 16'h0100, SEL_IR = 16'h0200, CAP_IR = 16'h0400, SH_IR = 16'h0800,
    EX1_IR = 16'h1000, PA_IR = 16'h2000, EX2_IR = 16'h4000, UPD_IR = 16'h8000
  } tap_state_t;
endpackage

/* core/stream_if.sv */
// Valid/ready stream between the controller and its sample buffer
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int W = 2) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* core/scan_buf.sv */
// Small FIFO between test-data sampling and register shifting
`timescale 1ns/1ns
`default_nettype none
module scan_buf #(
  parameter int W = 2,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  stream_if.snk fill,
  stream_if.src drain
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("scan_buf: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign fill.ready = (cnt_r != FULL_CNT);
  assign drain.valid = (cnt_r != '0);
  assign drain.data = mem_r[rp_r];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= fill.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= rp_r + AW'(1);
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_r <= cnt_r - (AW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

/* core/scan_tap.sv */
// Boundary-scan test access port with instruction, id, bypass and pin-cell chain
`timescale 1ns/1ns
`default_nettype none
module scan_tap
  import tap_pkg::*;
#(
  parameter logic [31:0] ID_CODE = 32'h0000_0001  // Arbitrary neutral value
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Test port pins
  input wire logic TCK_IN,
  input wire logic TMS_IN,
  input wire logic TDI_IN,
  input wire logic TRSTN_IN,
  output logic TDO_OUT,
  output logic TDO_OEN_OUT,
  // Debug interface choice
  input wire logic DEBUG_MODE_SELECT_IN,
  output logic DEBUG_IF_SELECT_OUT,
  // Pin cells
  input wire logic [CHAIN_LEN-1:0] CELL_SAMPLE_IN,
  input wire logic [CHAIN_LEN-1:0] CELL_PULLUP_IN,
  input wire logic [CHAIN_LEN-1:0] CELL_OPEN_DRAIN_IN,
  output logic [CHAIN_LEN-1:0] CELL_LATCH_OUT,
  // System mode
  output logic [INSTRUCTION_REGISTER_LEN-1:0] INSTRUCTION_REGISTER_OUT,
  output logic EXTEST_DRIVE_OUT,
  output logic HIGHZ_OUT,
  output logic GUARD_OUT
);
  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_r, sync2_r;
  logic tck_d_r, tck_rise, tck_fall, tms_s, tdi_s, trst_s, dbg_s;
  // Idle levels match the pull-ups so an unused port stays quiet
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
      tck_d_r <= SYNC_RST[S_TCK];
    end else begin
      sync1_r <= {DEBUG_MODE_SELECT_IN, TRSTN_IN, TDI_IN, TMS_IN, TCK_IN};
      sync2_r <= sync1_r;
      tck_d_r <= sync2_r[S_TCK];
    end
  end
  // Each test-clock phase must span a system clock to be seen
  assign tck_rise = sync2_r[S_TCK] && !tck_d_r;
  assign tck_fall = !sync2_r[S_TCK] && tck_d_r;
  assign tms_s = sync2_r[S_TMS];
  assign tdi_s = sync2_r[S_TDI];
  assign trst_s = sync2_r[S_TRSTN];
  assign dbg_s = sync2_r[S_DBG];
  // ----------------------------------------------------------------
  // Controller state machine
  // ----------------------------------------------------------------
  tap_state_t state_r, state_nxt;
  always_comb begin
    unique case (state_r)
      TLR: state_nxt = tms_s ? TLR : RTI;
      RTI: state_nxt = tms_s ? SEL_DR : RTI;
      SEL_DR: state_nxt = tms_s ? SEL_IR : CAP_DR;
      CAP_DR: state_nxt = tms_s ? EX1_DR : SH_DR;
      SH_DR: state_nxt = tms_s ? EX1_DR : SH_DR;
      EX1_DR: state_nxt = tms_s ? UPD_DR : PA_DR;
      PA_DR: state_nxt = tms_s ? EX2_DR : PA_DR;
      EX2_DR: state_nxt = tms_s ? UPD_DR : SH_DR;
      UPD_DR: state_nxt = tms_s ? SEL_DR : RTI;
      SEL_IR: state_nxt = tms_s ? TLR : CAP_IR;
      CAP_IR: state_nxt = tms_s ? EX1_IR : SH_IR;
      SH_IR: state_nxt = tms_s ? EX1_IR : SH_IR;
      EX1_IR: state_nxt = tms_s ? UPD_IR : PA_IR;
      PA_IR: state_nxt = tms_s ? EX2_IR : PA_IR;
      EX2_IR: state_nxt = tms_s ? UPD_IR : SH_IR;
      UPD_IR: state_nxt = tms_s ? SEL_DR : RTI;
      default: state_nxt = TLR;
    endcase
  end
  // Test reset and debug select act without any test-clock edge
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      state_r <= TLR;
    end else if (!trst_s || dbg_s) begin
      state_r <= TLR;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Sampling into the buffer at rise, draining at fall
  // ----------------------------------------------------------------
  stream_if #(.W(BUF_W)) fill_s ();
  stream_if #(.W(BUF_W)) drain_s ();
  logic pend_r, pop, pop_ir, pop_dr, pop_bit;
  logic [BUF_W-1:0] pend_data_r;
  // A sample waits here while the buffer is full
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      pend_r <= 1'b0;
      pend_data_r <= '0;
    end else if (tck_rise && (state_r == SH_DR || state_r == SH_IR)) begin
      pend_r <= 1'b1;
      pend_data_r <= {state_r == SH_IR, tdi_s};
    end else if (fill_s.ready) begin
      pend_r <= 1'b0;
    end
  end
  assign fill_s.valid = pend_r;
  assign fill_s.data = pend_data_r;
  assign drain_s.ready = tck_fall;
  assign pop = drain_s.valid && drain_s.ready;
  assign pop_ir = pop && drain_s.data[1];
  assign pop_dr = pop && !drain_s.data[1];
  assign pop_bit = drain_s.data[0];
  scan_buf #(.W(BUF_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(CLK_IN),
    .rst_n(RESETN_IN),
    .fill(fill_s),
    .drain(drain_s)
  );
  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  logic [INSTRUCTION_REGISTER_LEN-1:0] ir_sh_r, instruction_register_r;
  logic sel_id, sel_chain, sel_byp;
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      ir_sh_r <= IR_CAPTURE;
    end else if (tck_rise && state_r == CAP_IR) begin
      ir_sh_r <= IR_CAPTURE;
    end else if (pop_ir) begin
      ir_sh_r <= {pop_bit, ir_sh_r[INSTRUCTION_REGISTER_LEN-1:1]};
    end
  end
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN || state_r == TLR) begin
      instruction_register_r <= OP_IDCODE;
    end else if (tck_rise && state_r == UPD_IR) begin
      instruction_register_r <= ir_sh_r;
    end
  end
  assign sel_id = (instruction_register_r == OP_IDCODE);
  assign sel_chain = (instruction_register_r == OP_EXTEST || instruction_register_r == OP_SAMPLE);
  assign sel_byp = !sel_id && !sel_chain;
  // ----------------------------------------------------------------
  // Identification, bypass and pin-cell chain
  // ----------------------------------------------------------------
  logic [ID_LEN-1:0] id_sh_r;
  logic byp_r, dr_cap;
  logic [CHAIN_LEN-1:0] chain_r, latch_r, out_cell, cap_val;
  assign dr_cap = tck_rise && state_r == CAP_DR;
  // The output cell sits just below its control cell
  assign out_cell = {CELL_SAMPLE_IN[CHAIN_LEN-2:0], 1'b0};
  assign cap_val = (CELL_OPEN_DRAIN_IN & ~out_cell)
                 | (~CELL_OPEN_DRAIN_IN & (CELL_SAMPLE_IN | CELL_PULLUP_IN));
  // Serial input never reaches the code itself, only its shift copy
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN || (dr_cap && sel_id)) begin
      id_sh_r <= ID_CODE;
    end else if (pop_dr && sel_id) begin
      id_sh_r <= {pop_bit, id_sh_r[ID_LEN-1:1]};
    end
  end
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN || (dr_cap && sel_byp)) begin
      byp_r <= BYPASS_CAPTURE;
    end else if (pop_dr && sel_byp) begin
      byp_r <= pop_bit;
    end
  end
  // Clamp and high-z leave the chain untouched
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      chain_r <= '0;
    end else if (dr_cap && sel_chain) begin
      chain_r <= cap_val;
    end else if (pop_dr && sel_chain) begin
      chain_r <= {pop_bit, chain_r[CHAIN_LEN-1:1]};
    end
  end
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      latch_r <= '0;
    end else if (tck_rise && state_r == UPD_DR && sel_chain) begin
      latch_r <= chain_r;
    end
  end
  // ----------------------------------------------------------------
  // Serial output and system mode
  // ----------------------------------------------------------------
  logic tdo_r, tdo_nxt, ir_side, guard_r, drive_r, highz_r;
  assign ir_side = (state_r == CAP_IR || state_r == SH_IR || state_r == EX1_IR);
  always_comb begin
    if (ir_side) begin
      tdo_nxt = pop_ir ? ir_sh_r[1] : ir_sh_r[0];
    end else if (sel_id) begin
      tdo_nxt = pop_dr ? id_sh_r[1] : id_sh_r[0];
    end else if (sel_chain) begin
      tdo_nxt = pop_dr ? chain_r[1] : chain_r[0];
    end else begin
      tdo_nxt = pop_dr ? pop_bit : byp_r;
    end
  end
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      tdo_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= tdo_nxt;
    end
  end
  // Guard lifts only when a normal instruction takes over
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      guard_r <= 1'b0;
      drive_r <= 1'b0;
      highz_r <= 1'b0;
    end else begin
      guard_r <= (instruction_register_r == OP_EXTEST || instruction_register_r == OP_CLAMP || instruction_register_r == OP_HIGHZ);
      drive_r <= (instruction_register_r == OP_EXTEST || instruction_register_r == OP_CLAMP);
      highz_r <= (instruction_register_r == OP_HIGHZ);
    end
  end

  assign TDO_OUT = tdo_r;
  assign TDO_OEN_OUT = !(state_r == SH_DR || state_r == SH_IR);
  assign DEBUG_IF_SELECT_OUT = dbg_s;
  assign CELL_LATCH_OUT = latch_r;
  assign INSTRUCTION_REGISTER_OUT = instruction_register_r;
  assign EXTEST_DRIVE_OUT = drive_r;
  assign HIGHZ_OUT = highz_r;
  assign GUARD_OUT = guard_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  state_step_a: assert property (($changed(state_r) && $past(trst_s) && !$past(dbg_s)) |-> $past(tck_rise))
    else $error("state moved without a test-clock rise");
  shift_fall_a: assert property ($changed(chain_r) && !$past(dr_cap) |-> $past(tck_fall))
    else $error("chain shifted off a falling edge");
  tdo_fall_a: assert property ($changed(tdo_r) |-> $past(tck_fall))
    else $error("serial output changed off a falling edge");
  tdo_drive_a: assert property ($fell(TDO_OEN_OUT) |-> $past(tck_rise) && (state_r == SH_DR || state_r == SH_IR))
    else $error("serial output enabled outside a shift state");
  trst_now_a: assert property (!trst_s |=> state_r == TLR ##1 instruction_register_r == OP_IDCODE)
    else $error("test reset did not reset the controller");
  pullup_cap_a: assert property (dr_cap && sel_chain |=>
      ((chain_r & $past(CELL_PULLUP_IN & ~CELL_OPEN_DRAIN_IN)) == $past(CELL_PULLUP_IN & ~CELL_OPEN_DRAIN_IN)))
    else $error("pulled-up cell not captured as one");
  od_cap_a: assert property (dr_cap && sel_chain |=>
      ((chain_r ^ ~$past(out_cell)) & $past(CELL_OPEN_DRAIN_IN)) == '0)
    else $error("open-drain control cell captured wrong");
  guard_set_a: assert property ($rose(GUARD_OUT) |-> $past(state_r == UPD_IR, 2))
    else $error("guard raised without an instruction update");
  bypass_path_a: assert property (pop_dr && sel_byp && !ir_side |=> TDO_OUT == $past(pop_bit))
    else $error("bypass bit did not reach the serial output");
  debug_hold_a: assert property (dbg_s |=> state_r == TLR && TDO_OEN_OUT)
    else $error("debug select did not hold the controller");

  id_shift_c: cover property (sel_id && state_r == SH_DR && pop_dr);
  ir_update_c: cover property (tck_rise && state_r == UPD_IR);
  guard_c: cover property ($rose(GUARD_OUT));
  buf_full_c: cover property (!fill_s.ready);
endmodule
`default_nettype wire

/* test/jtag_host.sv */
// Behavioural external boundary-scan controller that drives the test port pins
`timescale 1ns/1ns
`default_nettype none
module jtag_host (
  // Clock and observed pins
  input wire logic clk_in,
  input wire logic tdo_in,
  input wire logic tdo_oen_in,
  // Driven pins
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic trstn_out
);
  int glitches;

  initial begin
    glitches = 0;
    tck_out = 1'b1;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    trstn_out = 1'b0;
  end

  // ----------------------------------------------------------------
  // One test-clock period of 160 ns, pins changed with its fall
  // ----------------------------------------------------------------
  task automatic tick(input logic m, input logic d, output logic q, output logic oe);
    logic q2;
    tms_out = m;
    tdi_out = d;
    repeat (4) @(negedge clk_in);
    tck_out = 1'b1;
    q = tdo_in;
    oe = tdo_oen_in;
    repeat (4) @(negedge clk_in);
    q2 = tdo_in;
    if (oe === 1'b0 && q2 !== q) glitches++;
    tck_out = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Session start: test reset pulse, then park in Run-Test/Idle
  // ----------------------------------------------------------------
  task automatic reset_link();
    logic q, oe;
    trstn_out = 1'b0;
    repeat (4) @(negedge clk_in);
    trstn_out = 1'b1;
    tck_out = 1'b0;
    repeat (4) @(negedge clk_in);
    tick(1'b0, 1'b1, q, oe);
  endtask

  // Full register scan from and back to Run-Test/Idle, low bit first
  task automatic scan(input logic ir, input int n, input logic [198:0] din,
                      output logic [198:0] dout, output logic oen_ok);
    logic q, oe;
    dout = '0;
    oen_ok = 1'b1;
    tick(1'b1, 1'b1, q, oe);
    if (ir) tick(1'b1, 1'b1, q, oe);
    tick(1'b0, 1'b1, q, oe);
    tick(1'b0, 1'b1, q, oe);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q, oe);
      dout[i] = q;
      if (oe !== 1'b0) oen_ok = 1'b0;
    end
    tick(1'b1, 1'b1, q, oe);
    if (oe !== 1'b1) oen_ok = 1'b0;
    tick(1'b0, 1'b1, q, oe);
  endtask
endmodule
`default_nettype wire

/* test/scan_tap_tb.sv */
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ns
`default_nettype none
module scan_tap_tb;
  import tap_pkg::*;
  localparam logic [31:0] TB_ID = 32'h0c3a_5e71;  // Arbitrary identification value
  logic clk = 1'b0;
  logic resetn, tck, tms, tdi, trstn, tdo, tdo_oen, dbg_sel, dbg_if, ext_drv, highz, guard, ok;
  logic [2:0] instruction_register;
  logic [CHAIN_LEN-1:0] samp, pull, od, latch, dout, din, exp_v;
  logic [2:0] codes [5] = '{OP_BYPASS, 3'h4, 3'h6, OP_CLAMP, OP_HIGHZ};
  int fail_count = 0;
  int checks_done = 0;

  always #10 clk = ~clk;

  scan_tap #(.ID_CODE(TB_ID)) dut (
    .CLK_IN(clk), .RESETN_IN(resetn), .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi), .TRSTN_IN(trstn),
    .TDO_OUT(tdo), .TDO_OEN_OUT(tdo_oen), .DEBUG_MODE_SELECT_IN(dbg_sel), .DEBUG_IF_SELECT_OUT(dbg_if),
    .CELL_SAMPLE_IN(samp), .CELL_PULLUP_IN(pull), .CELL_OPEN_DRAIN_IN(od), .CELL_LATCH_OUT(latch),
    .INSTRUCTION_REGISTER_OUT(instruction_register), .EXTEST_DRIVE_OUT(ext_drv), .HIGHZ_OUT(highz), .GUARD_OUT(guard)
  );

  jtag_host host (
    .clk_in(clk), .tdo_in(tdo), .tdo_oen_in(tdo_oen),
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trstn_out(trstn)
  );

  // ----------------------------------------------------------------
  // Comparison and closing
  // ----------------------------------------------------------------
  task automatic check_vec(input logic [CHAIN_LEN-1:0] got, input logic [CHAIN_LEN-1:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    fail_count++;
    $display("mismatch at %0t: run time limit reached", $time);
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    dbg_sel = 1'b0;
    samp = {1'b0, {66{3'b011}}};
    pull = '0;
    od = '0;
    din = {1'b1, {66{3'b100}}};
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    check_vec(CHAIN_LEN'(instruction_register), CHAIN_LEN'(OP_IDCODE), "reset instruction");
    check_bit(tdo_oen, 1'b1, "idle output enable");
    check_bit(guard, 1'b0, "idle guard");
    $display("test reset_state done");

    host.reset_link();
    repeat (2) begin
      host.scan(1'b0, 33, '1, dout, ok);
      check_vec(CHAIN_LEN'(dout[31:0]), CHAIN_LEN'(TB_ID), "id code");
      check_bit(dout[32], 1'b1, "id tail");
      check_bit(ok, 1'b1, "shift output enable");
    end
    $display("test id_read done");

    samp[198] = 1'b0;
    samp[196] = 1'b1;
    samp[194] = 1'b0;
    samp[193] = 1'b0;
    pull[198] = 1'b1;
    od[197] = 1'b1;
    od[194] = 1'b1;
    din[197] = 1'b0;
    exp_v[0] = samp[0] | pull[0];
    for (int i = 1; i < CHAIN_LEN; i++) exp_v[i] = od[i] ? ~samp[i - 1] : (samp[i] | pull[i]);
    host.scan(1'b1, 3, CHAIN_LEN'(OP_SAMPLE), dout, ok);
    check_vec(CHAIN_LEN'(dout[2:0]), CHAIN_LEN'(IR_CAPTURE), "instruction capture");
    check_vec(CHAIN_LEN'(instruction_register), CHAIN_LEN'(OP_SAMPLE), "sample selected");
    host.scan(1'b0, CHAIN_LEN, din, dout, ok);
    check_vec(dout, exp_v, "captured cells");
    check_vec(latch, din, "update latch");
    check_bit(guard, 1'b0, "sample unguarded");
    $display("test sample done");

    foreach (codes[k]) begin
      host.scan(1'b1, 3, CHAIN_LEN'(codes[k]), dout, ok);
      check_vec(CHAIN_LEN'(instruction_register), CHAIN_LEN'(codes[k]), "instruction");
      check_bit(guard, codes[k] == OP_CLAMP || codes[k] == OP_HIGHZ, "guard");
      check_bit(ext_drv, codes[k] == OP_CLAMP, "drive from latch");
      check_bit(highz, codes[k] == OP_HIGHZ, "high impedance");
      host.scan(1'b0, 4, CHAIN_LEN'(4'hb), dout, ok);
      check_vec(CHAIN_LEN'(dout[3:0]), CHAIN_LEN'(4'h6), "bypass path");
      check_vec(latch, din, "latch held");
    end
    $display("test bypass done");

    host.scan(1'b1, 3, CHAIN_LEN'(OP_EXTEST), dout, ok);
    check_bit(guard, 1'b1, "extest guard");
    check_bit(ext_drv, 1'b1, "extest drive");
    host.trstn_out = 1'b0;
    repeat (5) @(negedge clk);
    check_vec(CHAIN_LEN'(instruction_register), CHAIN_LEN'(OP_IDCODE), "test reset instruction");
    check_bit(guard, 1'b0, "test reset guard");
    host.reset_link();
    $display("test test_reset done");

    dbg_sel = 1'b1;
    repeat (4) @(negedge clk);
    check_bit(dbg_if, 1'b1, "debug select");
    host.scan(1'b1, 3, CHAIN_LEN'(OP_BYPASS), dout, ok);
    check_vec(CHAIN_LEN'(instruction_register), CHAIN_LEN'(OP_IDCODE), "scan ignored in debug");
    check_bit(tdo_oen, 1'b1, "debug output enable");
    dbg_sel = 1'b0;
    repeat (4) @(negedge clk);
    check_bit(dbg_if, 1'b0, "debug released");
    check_bit(host.glitches == 0, 1'b1, "output changes at falls only");
    $display("test debug_select done");
    report_and_stop();
  end
endmodule
`default_nettype wire
